// ---- design/frao_pkg.sv ----
// Shared constants and types of the OTP, resume and address-mode block
package frao_pkg;
    // -----------------------------------------------------------------
    // Command codes
    // -----------------------------------------------------------------
    localparam logic [7:0] CMD_RESUME = 8'h7a;
    localparam logic [7:0] CMD_ENTER4 = 8'hb7;
    localparam logic [7:0] CMD_EXIT4 = 8'he9;
    localparam logic [7:0] CMD_OTP_PROG = 8'h42;
    localparam logic [7:0] CMD_OTP_READ = 8'h4b;
    localparam logic [7:0] CMD_WREN = 8'h06;
    // -----------------------------------------------------------------
    // OTP layout, link framing and timing
    // -----------------------------------------------------------------
    localparam int OTP_SLOTS = 65;
    localparam logic [7:0] OTP_LAST = 8'h40;
    localparam int CTRL_BYTE = 64;
    localparam int LOCK_BIT = 0;
    localparam logic [7:0] OTP_ERASED = 8'hff;
    localparam logic [1:0] ADDR_LEN3 = 2'h2;
    localparam logic [1:0] ADDR_LEN4 = 2'h3;
    localparam logic [4:0] OTP_READ_DUMMY = 5'h08;
    localparam logic [4:0] DUMMY_LAST = 5'h01;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [7:0] OE_SINGLE = 8'h02;
    localparam logic [7:0] OE_OCTAL = 8'hff;
    localparam int CORE_CLK_NS = 40;
    localparam int TIMER_W = 24;
    localparam logic [TIMER_W-1:0] TIMER_LAST = 24'h000001;
    // -----------------------------------------------------------------
    // Types
    // -----------------------------------------------------------------
    typedef enum logic [6:0] {
        PH_CMD = 7'h01,
        PH_EXT = 7'h02,
        PH_ADDR = 7'h04,
        PH_DUMMY = 7'h08,
        PH_RDATA = 7'h10,
        PH_WDATA = 7'h20,
        PH_SKIP = 7'h40
    } frao_phase_e;
    typedef struct packed {
        logic ready;
        logic rsv6;
        logic rsv5;
        logic prog_fail;
        logic rsv3;
        logic rsv2;
        logic prot;
        logic rsv0;
    } frao_flag_s;
    typedef struct packed {
        logic [5:0] rsv;
        logic wel;
        logic wip;
    } frao_stat_s;
    localparam frao_flag_s FSR_RESET = frao_flag_s'(8'h80);
    typedef struct packed {
        frao_phase_e phase;
        logic [7:0] cmd;
        logic got_cmd;
        logic [1:0] acnt;
        logic [7:0] loc;
        logic [4:0] dcnt;
        logic [2:0] bitcnt;
        logic [7:0] sreg;
        logic [7:0] sout;
        logic any_data;
        logic [OTP_SLOTS-1:0][7:0] wbuf;
        logic [OTP_SLOTS-1:0] wmask;
    } frao_link_s;
    localparam int LINK_W = $bits(frao_link_s);
    localparam frao_link_s LINK_IDLE = frao_link_s'({PH_CMD, {(LINK_W - 7){1'b0}}});
    typedef struct packed {
        logic cs_prev;
        logic wip;
        logic wel;
        logic prog_busy;
        logic resume_busy;
        logic resume_pulse;
        logic addr4;
        frao_flag_s flags;
        logic [TIMER_W-1:0] timer;
        logic [OTP_SLOTS-1:0][7:0] otp;
        logic [OTP_SLOTS-1:0][7:0] pbuf;
        logic [OTP_SLOTS-1:0] pmask;
    } frao_core_s;
    localparam frao_core_s CORE_IDLE = '{
        cs_prev: 1'b1,
        flags: FSR_RESET,
        otp: {OTP_SLOTS{OTP_ERASED}},
        default: '0
    };
endpackage

// ---- design/frao_sync.sv ----
// Level synchroniser, with agreement filter when three or more stages are used
`timescale 1ns/1ps
module frao_sync #(
    parameter int STAGES = 3,
    parameter logic INIT = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic [STAGES-1:0] chain;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chain <= {STAGES{INIT}};
        end else begin
            chain <= {chain[STAGES-2:0], d};
        end
    end
    generate
        if (STAGES > 2) begin : g_filt
            logic held;
            // First stage is never compared, only the last two
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    held <= INIT;
                end else if (chain[STAGES-1] == chain[STAGES-2]) begin
                    held <= chain[STAGES-1];
                end
            end
            assign q = held;
        end else begin : g_plain
            assign q = chain[STAGES-1];
        end
    endgenerate
endmodule

// ---- design/frao_top.sv ----
// Command logic for resume, OTP read/program and address-length mode
// Functional notes
// R1 - Accepted resume sets write-in-progress and clears controller-ready
// R2 - Resume with nothing suspended is ignored, status untouched
// R3 - Ready reads 0 while resumed operation runs, returns 1 when done
// R4 - Host frames resume: select low, code on data lines, select high
// R5 - Octal mode carries everything on eight lines, both edges, 4-byte address; read data here changes on the falling edge only, one byte per cycle
// R6 - Single mode: command/address in on rising edge, data out on falling
// R7 - Read address advances each byte and sticks at location 0x40
// R8 - Read ends and outputs release whenever select goes high
// R9 - OTP program without write enable latch is ignored, no flags
// R10 - Select must rise on a byte boundary, else no execution, latch kept
// R11 - At least one data byte; at most 65 latched, rest discarded
// R12 - One program writes at most 64 data bytes plus control byte
// R13 - Timed program starts on select rise; busy bit high throughout
// R14 - Write enable latch cleared after program, pass or fail
// R15 - Program over its time limit clears latch and sets fail flag
// R16 - Host polls until ready bit 7 reads 1 after program
// R17 - Control byte bit 0 at 1 permits programming, 0 locks area
// R18 - Lock is permanent; later program ignored, latch kept, flags 1 and 4; here RST reloads every OTP byte with 0xff, which unlocks it
// R19 - Enter/exit 4-byte commands take effect for the next command
// R20 - Extended protocol defaults to 3-byte address, 4 only when entered
// R21 - Octal protocol always uses 4-byte addressing
// R22 - Flag bit 4 marks a rejected or failed program
`timescale 1ns/1ps
module frao_top #(
    parameter int OTP_PROGRAM_TIME_NS = 100000
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic LINK_CLK,
    input wire logic CS_N,
    input wire logic [7:0] DATA_LINES_IN,
    output logic [7:0] DATA_LINES_OUT,
    output logic [7:0] DATA_LINES_OE,
    input wire logic OCTAL_MODE,
    input wire logic SUSPENDED,
    input wire logic OP_DONE,
    input wire logic PROG_FAULT,
    input wire logic CLEAR_FLAGS,
    output logic RESUME_START,
    output frao_pkg::frao_stat_s STATUS,
    output frao_pkg::frao_flag_s FLAG_STATUS,
    output logic ADDR_4BYTE,
    output logic OTP_LOCKED
);
    localparam int PROG_CYCLES_I = OTP_PROGRAM_TIME_NS / frao_pkg::CORE_CLK_NS;
    localparam logic [frao_pkg::TIMER_W-1:0] PROG_CYCLES =
        (PROG_CYCLES_I < 1) ? frao_pkg::TIMER_LAST : frao_pkg::TIMER_W'(PROG_CYCLES_I);

    frao_pkg::frao_link_s l;
    frao_pkg::frao_link_s next_l;
    frao_pkg::frao_core_s c;
    frao_pkg::frao_core_s next_c;
    logic [7:0] rise_q;
    logic armed;
    logic link_arm;
    logic addr4_l;
    logic alen4;
    logic cs_f;
    logic frame_end;
    logic rd_on;
    logic serial_in_line;
    logic serial_out_line;

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function automatic logic [7:0] next_loc(input logic [7:0] loc);
        return (loc >= frao_pkg::OTP_LAST) ? frao_pkg::OTP_LAST : 8'(loc + 8'h01);
    endfunction

    function automatic frao_pkg::frao_link_s decide(input frao_pkg::frao_link_s s,
                                                    input logic len4);
        frao_pkg::frao_link_s r;
        r = s;
        if (s.cmd == frao_pkg::CMD_OTP_READ || s.cmd == frao_pkg::CMD_OTP_PROG) begin
            r.phase = frao_pkg::PH_ADDR;
            r.acnt = len4 ? frao_pkg::ADDR_LEN4 : frao_pkg::ADDR_LEN3; // see R20
        end else begin
            r.phase = frao_pkg::PH_SKIP;
        end
        return r;
    endfunction

    function automatic frao_pkg::frao_link_s take_byte(input frao_pkg::frao_link_s s,
                                                       input logic [7:0] b,
                                                       input logic len4,
                                                       input logic octal);
        frao_pkg::frao_link_s r;
        r = s;
        case (s.phase)
            frao_pkg::PH_CMD: begin
                r.cmd = b;
                r.got_cmd = 1'b1;
                if (octal) begin
                    r.phase = frao_pkg::PH_EXT;
                end else begin
                    r = decide(r, len4);
                end
            end
            frao_pkg::PH_EXT: begin
                r = decide(r, 1'b1); // see R21
            end
            frao_pkg::PH_ADDR: begin
                r.acnt = 2'(s.acnt - 2'h1);
                if (s.acnt == 2'h0) begin
                    // Only the last address byte selects an OTP location
                    if (s.cmd == frao_pkg::CMD_OTP_READ) begin
                        r.phase = frao_pkg::PH_DUMMY; // see R6
                        r.dcnt = frao_pkg::OTP_READ_DUMMY;
                        r.loc = (b > frao_pkg::OTP_LAST) ? frao_pkg::OTP_LAST : b;
                    end else begin
                        r.phase = frao_pkg::PH_WDATA;
                        r.loc = b;
                    end
                end
            end
            frao_pkg::PH_WDATA: begin
                r.any_data = 1'b1;
                // No rollover: past location 64 bytes are dropped
                if (s.loc <= frao_pkg::OTP_LAST) begin // see R11
                    r.wbuf[s.loc[6:0]] = b;
                    r.wmask[s.loc[6:0]] = 1'b1;
                    r.loc = 8'(s.loc + 8'h01);
                end
            end
            default: begin
            end
        endcase
        return r;
    endfunction

    // -----------------------------------------------------------------
    // Link domain
    // -----------------------------------------------------------------
    assign link_arm = RST | CS_N;
    assign alen4 = addr4_l | OCTAL_MODE;
    assign serial_in_line = rise_q[0];

    frao_sync #(
        .STAGES(3),
        .INIT(1'b0)
    ) u_addr4_sync (
        .clk(LINK_CLK),
        .rst(RST),
        .d(c.addr4),
        .q(addr4_l)
    );

    // Rising-edge sample of the lines
    always_ff @(posedge LINK_CLK or posedge RST) begin // see R6
        if (RST) begin
            rise_q <= 8'h00;
        end else begin
            rise_q <= DATA_LINES_IN;
        end
    end

    // Set while deselected; the clock may stop, so the frame start is marked here
    always_ff @(negedge LINK_CLK or posedge link_arm) begin
        if (link_arm) begin
            armed <= 1'b1;
        end else begin
            armed <= 1'b0;
        end
    end

    always_comb begin
        frao_pkg::frao_link_s base;
        base = armed ? frao_pkg::LINK_IDLE : l;
        next_l = base;
        if (base.phase == frao_pkg::PH_DUMMY) begin
            next_l.dcnt = 5'(base.dcnt - 5'h01);
            if (base.dcnt == frao_pkg::DUMMY_LAST) begin
                next_l.phase = frao_pkg::PH_RDATA;
                next_l.sout = c.otp[base.loc[6:0]];
                next_l.loc = next_loc(base.loc); // see R7
                next_l.bitcnt = 3'h0;
            end
        end else if (base.phase == frao_pkg::PH_RDATA) begin
            if (OCTAL_MODE || base.bitcnt == frao_pkg::BIT_LAST) begin
                next_l.sout = c.otp[base.loc[6:0]];
                next_l.loc = next_loc(base.loc); // see R7
                next_l.bitcnt = 3'h0;
            end else begin
                next_l.sout = {base.sout[6:0], 1'b0}; // see R6
                next_l.bitcnt = 3'(base.bitcnt + 3'h1);
            end
        end else if (OCTAL_MODE) begin
            // Rising byte first, then the falling byte of the same cycle
            next_l = take_byte(take_byte(base, rise_q, 1'b1, 1'b1),
                               DATA_LINES_IN, 1'b1, 1'b1); // see R5
        end else begin
            next_l.sreg = {base.sreg[6:0], serial_in_line};
            next_l.bitcnt = 3'(base.bitcnt + 3'h1);
            if (base.bitcnt == frao_pkg::BIT_LAST) begin
                next_l = take_byte(next_l, {base.sreg[6:0], serial_in_line}, alen4, 1'b0);
            end
        end
    end

    always_ff @(negedge LINK_CLK or posedge RST) begin
        if (RST) begin
            l <= frao_pkg::LINK_IDLE;
        end else begin
            l <= next_l;
        end
    end

    // Enable is combinational so a select rise drops the lines at once
    assign rd_on = (l.phase == frao_pkg::PH_RDATA) & ~armed & ~CS_N; // see R8
    assign serial_out_line = l.sout[7];
    assign DATA_LINES_OUT = OCTAL_MODE ? l.sout : {6'h00, serial_out_line, 1'b0};
    assign DATA_LINES_OE = rd_on ? (OCTAL_MODE ? frao_pkg::OE_OCTAL : frao_pkg::OE_SINGLE)
                                 : 8'h00;

    // -----------------------------------------------------------------
    // Core domain
    // -----------------------------------------------------------------
    frao_sync #(
        .STAGES(3),
        .INIT(1'b1)
    ) u_cs_sync (
        .clk(CORE_CLK),
        .rst(RST),
        .d(CS_N),
        .q(cs_f)
    );

    // Link fields are settled here: no link edge while deselected
    assign frame_end = cs_f & ~c.cs_prev;

    always_comb begin
        next_c = c;
        next_c.cs_prev = cs_f;
        next_c.resume_pulse = 1'b0;
        if (CLEAR_FLAGS) begin
            next_c.flags.prog_fail = 1'b0;
            next_c.flags.prot = 1'b0;
        end
        if (c.prog_busy) begin
            if (c.timer == frao_pkg::TIMER_LAST) begin
                next_c.prog_busy = 1'b0;
                next_c.wip = 1'b0; // see R13
                next_c.flags.ready = 1'b1; // see R16
                next_c.wel = 1'b0; // see R14
                if (PROG_FAULT) begin
                    next_c.flags.prog_fail = 1'b1; // see R15
                end else begin
                    // Bits only program towards 0, so a cleared lock stays cleared
                    for (int i = 0; i < frao_pkg::OTP_SLOTS; i++) begin // see R12
                        if (c.pmask[i]) begin
                            next_c.otp[i] = c.otp[i] & c.pbuf[i]; // see R17
                        end
                    end
                end
            end else begin
                next_c.timer = frao_pkg::TIMER_W'(c.timer - frao_pkg::TIMER_LAST);
            end
        end
        if (c.resume_busy && OP_DONE) begin
            next_c.resume_busy = 1'b0;
            next_c.wip = 1'b0;
            next_c.flags.ready = 1'b1; // see R3
        end
        if (frame_end && l.got_cmd && !c.wip) begin
            case (l.cmd)
                frao_pkg::CMD_RESUME: begin
                    if (SUSPENDED) begin // see R2
                        next_c.wip = 1'b1; // see R1
                        next_c.flags.ready = 1'b0; // see R3
                        next_c.resume_busy = 1'b1;
                        next_c.resume_pulse = 1'b1;
                    end
                end
                frao_pkg::CMD_ENTER4: begin
                    next_c.addr4 = 1'b1; // see R19
                end
                frao_pkg::CMD_EXIT4: begin
                    next_c.addr4 = 1'b0; // see R20
                end
                frao_pkg::CMD_WREN: begin
                    next_c.wel = 1'b1;
                end
                frao_pkg::CMD_OTP_PROG: begin
                    if (!c.wel) begin
                        next_c.wel = 1'b0; // see R9
                    end else if (l.bitcnt != 3'h0 || !l.any_data) begin
                        next_c.wel = 1'b1; // see R10
                    end else if (!c.otp[frao_pkg::CTRL_BYTE][frao_pkg::LOCK_BIT]) begin
                        next_c.flags.prot = 1'b1; // see R18
                        next_c.flags.prog_fail = 1'b1; // see R22
                    end else begin
                        // Own copy, so polling frames cannot disturb the data
                        next_c.pbuf = l.wbuf;
                        next_c.pmask = l.wmask;
                        next_c.prog_busy = 1'b1;
                        next_c.wip = 1'b1; // see R13
                        next_c.flags.ready = 1'b0;
                        next_c.timer = PROG_CYCLES;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            c <= frao_pkg::CORE_IDLE;
        end else begin
            c <= next_c;
        end
    end

    assign STATUS = '{rsv: 6'h00, wel: c.wel, wip: c.wip};
    assign FLAG_STATUS = c.flags;
    assign RESUME_START = c.resume_pulse;
    assign ADDR_4BYTE = c.addr4 | OCTAL_MODE; // see R21
    assign OTP_LOCKED = ~c.otp[frao_pkg::CTRL_BYTE][frao_pkg::LOCK_BIT];

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    logic [frao_pkg::TIMER_W-1:0] prog_len;
    logic cmd_seen;
    assign cmd_seen = frame_end && l.got_cmd && !c.wip;
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            prog_len <= '0;
        end else if (c.prog_busy) begin
            prog_len <= frao_pkg::TIMER_W'(prog_len + frao_pkg::TIMER_LAST);
        end else begin
            prog_len <= '0;
        end
    end

    property p_resume_go;
        @(posedge CORE_CLK) disable iff (RST)
        cmd_seen && l.cmd == frao_pkg::CMD_RESUME && SUSPENDED
        |=> STATUS.wip && !FLAG_STATUS.ready && RESUME_START ##1 !RESUME_START;
    endproperty
    a_resume_go: assert property (p_resume_go) else $error("resume not taken"); // see R1

    property p_resume_ign;
        @(posedge CORE_CLK) disable iff (RST)
        cmd_seen && l.cmd == frao_pkg::CMD_RESUME && !SUSPENDED && !CLEAR_FLAGS
        && !c.prog_busy && !c.resume_busy
        |=> $stable(STATUS) && $stable(FLAG_STATUS) && !RESUME_START;
    endproperty
    a_resume_ign: assert property (p_resume_ign) else $error("stray resume acted"); // see R2

    property p_resume_done;
        @(posedge CORE_CLK) disable iff (RST)
        c.resume_busy && OP_DONE |=> FLAG_STATUS.ready && !STATUS.wip;
    endproperty
    a_resume_done: assert property (p_resume_done) else $error("ready not back"); // see R3

    property p_prog_len;
        @(posedge CORE_CLK) disable iff (RST)
        $fell(c.prog_busy) |-> prog_len == PROG_CYCLES && !STATUS.wip && !STATUS.wel;
    endproperty
    a_prog_len: assert property (p_prog_len) else $error("program length wrong"); // see R13

    property p_busy_bits;
        @(posedge CORE_CLK) disable iff (RST)
        c.prog_busy |-> STATUS.wip && !FLAG_STATUS.ready;
    endproperty
    a_busy_bits: assert property (p_busy_bits) else $error("busy bits wrong"); // see R16

    property p_timeout;
        @(posedge CORE_CLK) disable iff (RST)
        c.prog_busy && c.timer == frao_pkg::TIMER_LAST && PROG_FAULT
        |=> FLAG_STATUS.prog_fail && !STATUS.wel && $stable(c.otp);
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout not flagged"); // see R15

    property p_no_wel;
        @(posedge CORE_CLK) disable iff (RST)
        cmd_seen && l.cmd == frao_pkg::CMD_OTP_PROG && !c.wel && !CLEAR_FLAGS
        |=> !c.prog_busy && $stable(FLAG_STATUS) && !STATUS.wel;
    endproperty
    a_no_wel: assert property (p_no_wel) else $error("program ran without latch"); // see R9

    property p_unaligned;
        @(posedge CORE_CLK) disable iff (RST)
        cmd_seen && l.cmd == frao_pkg::CMD_OTP_PROG && c.wel && l.bitcnt != 3'h0
        && !CLEAR_FLAGS
        |=> !c.prog_busy && STATUS.wel && $stable(FLAG_STATUS);
    endproperty
    a_unaligned: assert property (p_unaligned) else $error("ragged frame ran"); // see R10

    property p_locked;
        @(posedge CORE_CLK) disable iff (RST)
        cmd_seen && l.cmd == frao_pkg::CMD_OTP_PROG && c.wel && l.bitcnt == 3'h0
        && l.any_data && OTP_LOCKED
        |=> !c.prog_busy && STATUS.wel && FLAG_STATUS.prot && FLAG_STATUS.prog_fail
        && OTP_LOCKED;
    endproperty
    a_locked: assert property (p_locked) else $error("locked area programmed"); // see R18

    property p_lock_keep;
        @(posedge CORE_CLK) disable iff (RST)
        OTP_LOCKED |=> OTP_LOCKED;
    endproperty
    a_lock_keep: assert property (p_lock_keep) else $error("lock bit returned"); // see R17

    property p_enter4;
        @(posedge CORE_CLK) disable iff (RST)
        cmd_seen && l.cmd == frao_pkg::CMD_ENTER4 |=> ADDR_4BYTE ##1 c.addr4;
    endproperty
    a_enter4: assert property (p_enter4) else $error("4-byte mode not entered"); // see R19

    property p_release;
        @(posedge CORE_CLK) disable iff (RST)
        CS_N |-> DATA_LINES_OE == 8'h00;
    endproperty
    a_release: assert property (p_release) else $error("lines driven deselected"); // see R8

    property p_read_cap;
        @(negedge LINK_CLK) disable iff (RST)
        l.phase == frao_pkg::PH_RDATA |-> l.loc <= frao_pkg::OTP_LAST;
    endproperty
    a_read_cap: assert property (p_read_cap) else $error("read address wrapped"); // see R7
endmodule

// ---- verif/frao_host.sv ----
// Host controller model driving the single-line link
`timescale 1ns/1ps
module frao_host (
    output logic cs_n,
    output logic sclk,
    output logic [7:0] din,
    input wire logic [7:0] dout
);
    // ---------------------------------------------
    // Frame control and bit transfer
    // ---------------------------------------------
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 8'h00;
        // One link clock pulse, rise and fall, inside reset, then the clock stands still
        #100 sclk = 1'b1;
        #80 sclk = 1'b0;
    end
    task automatic sel();
        #80 cs_n = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            din[0] = b[i];
            #80 sclk = 1'b1;
            r[i] = dout[1];
            #80 sclk = 1'b0;
        end
    endtask
    task automatic desel();
        #80 cs_n = 1'b1;
        // Released line must not keep showing the last bit
        din = ~din;
    endtask
endmodule

// ---- verif/test_frao_top.sv ----
// Self-checking bench for the resume, OTP and address-mode block
`timescale 1ns/1ps
module test_frao_top;
    localparam logic [7:0] RES = frao_pkg::CMD_RESUME;
    localparam logic [7:0] PRG = frao_pkg::CMD_OTP_PROG;
    localparam logic [7:0] WEN = frao_pkg::CMD_WREN;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic susp = 1'b0;
    logic done = 1'b0;
    logic clr = 1'b0;
    logic oct = 1'b0;
    logic fault = 1'b0;
    logic sclk, cs_n, addr4, locked;
    logic [7:0] din, dout, oe;
    logic [7:0] rd [3];
    frao_pkg::frao_stat_s st;
    frao_pkg::frao_flag_s fl;
    int mismatches = 0;
    int compares = 0;
    always #20 clk = ~clk;
    frao_host i_host (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));
    frao_top #(.OTP_PROGRAM_TIME_NS(400)) i_dut (
        .CORE_CLK(clk), .RST(rst), .LINK_CLK(sclk), .CS_N(cs_n),
        .DATA_LINES_IN(din), .DATA_LINES_OUT(dout), .DATA_LINES_OE(oe),
        .OCTAL_MODE(oct), .SUSPENDED(susp), .OP_DONE(done), .PROG_FAULT(fault),
        .CLEAR_FLAGS(clr), .RESUME_START(), .STATUS(st), .FLAG_STATUS(fl),
        .ADDR_4BYTE(addr4), .OTP_LOCKED(locked));
    // ---------------------------------------------
    // Tasks
    // ---------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic frame(input logic [7:0] q[$], input int nrd);
        logic [7:0] r;
        i_host.sel();
        foreach (q[i]) i_host.xfer(q[i], r);
        for (int i = 0; i < nrd; i++) begin
            i_host.xfer(8'h00, r);
            rd[i] = r;
        end
        if (nrd > 0) chk(oe, 8'h02);
        i_host.desel();
        #1 chk(oe, 8'h00);
        // Core needs the deselect gap to see the frame end
        repeat (8) @(posedge clk);
        // Look after the edge, once its updates have settled
        #1;
    endtask
    // ---------------------------------------------
    // Sequence
    // ---------------------------------------------
    initial begin
        #500000;
        mismatches++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        chk(st, 8'h00);
        chk(fl, 8'h80);
        chk({7'h00, addr4}, 8'h00);
        @(posedge clk) oct <= 1'b1;
        @(posedge clk) #1 chk({7'h00, addr4}, 8'h01);
        @(posedge clk) oct <= 1'b0;
        @(posedge clk);
        frame('{RES}, 0);
        chk(st, 8'h00);
        chk(fl, 8'h80);
        @(posedge clk) susp <= 1'b1;
        frame('{RES}, 0);
        chk(st, 8'h01);
        chk(fl, 8'h00);
        @(posedge clk) done <= 1'b1;
        @(posedge clk) done <= 1'b0;
        susp <= 1'b0;
        repeat (2) @(posedge clk);
        chk(fl, 8'h80);
        frame('{frao_pkg::CMD_ENTER4}, 0);
        chk({7'h00, addr4}, 8'h01);
        frame('{frao_pkg::CMD_EXIT4}, 0);
        chk({7'h00, addr4}, 8'h00);
        frame('{PRG, 8'h00, 8'h00, 8'h3f, 8'haa}, 0);
        chk(st, 8'h00);
        chk(fl, 8'h80);
        @(posedge clk) fault <= 1'b1;
        frame('{WEN}, 0);
        frame('{PRG, 8'h00, 8'h00, 8'h10, 8'h00}, 0);
        repeat (20) @(posedge clk);
        #1 chk(st, 8'h00);
        chk(fl, 8'h90);
        @(posedge clk) fault <= 1'b0;
        clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        frame('{WEN}, 0);
        frame('{PRG, 8'h00, 8'h00, 8'h3f, 8'haa, 8'hfe, 8'h55}, 0);
        chk(st, 8'h03);
        chk(fl, 8'h00);
        repeat (20) @(posedge clk);
        chk(st, 8'h00);
        chk(fl, 8'h80);
        chk({7'h00, locked}, 8'h01);
        frame('{frao_pkg::CMD_OTP_READ, 8'h00, 8'h00, 8'h3f, 8'h00}, 3);
        chk(rd[0], 8'haa);
        chk(rd[1], 8'hfe);
        chk(rd[2], 8'hfe);
        frame('{WEN}, 0);
        frame('{PRG, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
        chk(st, 8'h02);
        chk(fl, 8'h92);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        @(posedge clk);
        chk(fl, 8'h80);
        final_report();
    end
endmodule
